// [dbh_host.sv]
// module: host controller that loads double-buffered 12-bit converters through their pins
// Function
// - host forms strobe from select and write
// - several enables in one write allowed
// - 4-bit bus: four locations per converter
// - 8-bit bus: two byte writes per word
// - base select plus two low address bits
// - right-justified: low byte, then high+transfer
// - left-justified: two writes, last transfers
// - four converters use eight byte addresses
// - ninth address loads every converter together
// - last-loaded converter low nibble updates all
// - wide bus: all nibble enables held low
// - wide bus: load enable from decoder, strobed
`timescale 1ns/1ps
`default_nettype none
module dbh_host #(
	parameter int unsigned NUM_DACS       = dbh_pkg::DBH_NUM_DACS,
	parameter bit          LAST_LOADS_ALL = 1'b0,
	parameter int unsigned TGT_W          = (NUM_DACS > 1) ? $clog2(NUM_DACS) : 1
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// command port
	input  wire logic                  cmd_valid_in,
	input  wire dbh_pkg::dbh_mode_type cmd_mode_in,
	input  wire logic [TGT_W-1:0]      cmd_target_in,
	input  wire logic [11:0]           cmd_word_in,
	input  wire logic                  cmd_load_in,
	output var  logic                  cmd_ready_out,
	output var  logic                  cmd_done_out,
	// converter pins
	output var  logic                  write_strobe_n_out,
	output var  logic [3*NUM_DACS-1:0] nibble_enable_n_out,
	output var  logic [NUM_DACS-1:0]   converter_load_enable_n_out,
	output var  logic [11:0]           data_inputs_out
);
	import dbh_pkg::*;

	typedef struct packed {
		logic [2:0] nib;
		logic       converter_load_enable_n;
		logic       last;
	} dbh_step_type;

	typedef enum logic [1:0] {DBH_ST_IDLE, DBH_ST_ISSUE, DBH_ST_WAIT} dbh_st_type;

	// ==========================================================
	// write plan per mode; all modes drive the whole word on the data pins and
	// only the enabled nibbles take it
	function automatic dbh_step_type plan_step(input dbh_mode_type mode,
						   input logic [1:0] step, input logic load);
		dbh_step_type s;
		s = '{nib: DBH_NIB_NONE, converter_load_enable_n: 1'b0, last: 1'b1};
		unique case (mode)
			DBH_MODE_NIBBLE: begin
				// one location per latch, load enable on the fourth
				if (step == DBH_STEP_W0) begin
					s = '{nib: DBH_NIB_HI_M, converter_load_enable_n: 1'b0, last: 1'b0};
				end else if (step == DBH_STEP_W1) begin
					s = '{nib: DBH_NIB_MID_M, converter_load_enable_n: 1'b0, last: 1'b0};
				end else if (step == DBH_STEP_W2) begin
					s = '{nib: DBH_NIB_LO_M, converter_load_enable_n: 1'b0, last: !load};
				end else begin
					s = '{nib: DBH_NIB_NONE, converter_load_enable_n: 1'b1, last: 1'b1};
				end
			end
			DBH_MODE_BYTE_RIGHT: begin
				// low byte first, high nibble together with the transfer
				if (step == DBH_STEP_W0) begin
					s = '{nib: DBH_NIB_LOBYTE, converter_load_enable_n: 1'b0, last: 1'b0};
				end else begin
					s = '{nib: DBH_NIB_HI_M, converter_load_enable_n: load, last: 1'b1};
				end
			end
			DBH_MODE_BYTE_LEFT: begin
				if (step == DBH_STEP_W0) begin
					s = '{nib: DBH_NIB_HIBYTE, converter_load_enable_n: 1'b0, last: 1'b0};
				end else begin
					s = '{nib: DBH_NIB_LO_M, converter_load_enable_n: load, last: 1'b1};
				end
			end
			DBH_MODE_WORD: begin
				s = '{nib: DBH_NIB_ALL, converter_load_enable_n: load, last: 1'b1};
			end
			DBH_MODE_UPDATE_ALL: begin
				s = '{nib: DBH_NIB_NONE, converter_load_enable_n: 1'b1, last: 1'b1};
			end
			default: begin
				s = '{nib: DBH_NIB_NONE, converter_load_enable_n: 1'b0, last: 1'b1};
			end
		endcase
		return s;
	endfunction

	dbh_wr_if #(.NUM_DACS(NUM_DACS)) wr ();

	dbh_st_type            st_q, st_d;
	logic [1:0]            step_q, step_d;
	dbh_mode_type          mode_q, mode_d;
	logic [TGT_W-1:0]      tgt_q, tgt_d;
	logic [11:0]           word_q, word_d;
	logic                  load_q, load_d;
	logic                  ready_q, ready_d;
	logic                  done_q, done_d;
	dbh_step_type          cur;
	logic [NUM_DACS-1:0]   tgt_oh;

	// ==========================================================
	// sequencer
	always_comb begin
		cur    = plan_step(mode_q, step_q, load_q);
		tgt_oh = '0;
		tgt_oh[tgt_q] = 1'b1;
		st_d   = st_q;
		step_d = step_q;
		mode_d = mode_q;
		tgt_d  = tgt_q;
		word_d = word_q;
		load_d = load_q;
		done_d = 1'b0;
		unique case (st_q)
			DBH_ST_IDLE: begin
				if (cmd_valid_in && ready_q) begin
					mode_d = cmd_mode_in;
					tgt_d  = cmd_target_in;
					word_d = cmd_word_in;
					// without load the word only waits in the input latches
					load_d = cmd_load_in;
					step_d = DBH_STEP_W0;
					st_d   = DBH_ST_ISSUE;
				end
			end
			DBH_ST_ISSUE: begin
				st_d = DBH_ST_WAIT;
			end
			DBH_ST_WAIT: begin
				if (!wr.busy) begin
					if (cur.last) begin
						done_d = 1'b1;
						st_d   = DBH_ST_IDLE;
					end else begin
						step_d = step_q + 2'h1;
						st_d   = DBH_ST_ISSUE;
					end
				end
			end
			default: begin
				st_d = DBH_ST_IDLE;
			end
		endcase
		ready_d = (st_d == DBH_ST_IDLE);
	end

	// ==========================================================
	// write request toward the strobe generator
	always_comb begin
		wr.req  = (st_q == DBH_ST_ISSUE);
		wr.nib  = cur.nib;
		wr.tgt  = (mode_q == DBH_MODE_UPDATE_ALL) ? '0 : tgt_oh;
		wr.data = word_q;
		wr.converter_load_enable_n = '0;
		if (cur.converter_load_enable_n) begin
			// broadcast reaches all converters in one strobe
			wr.converter_load_enable_n = (mode_q == DBH_MODE_UPDATE_ALL) ? '1 : tgt_oh;
		end
		// shared load line tied to the last converter's low nibble enable
		if (LAST_LOADS_ALL && tgt_oh[NUM_DACS-1] && cur.nib[DBH_NIB_LO]
		    && mode_q != DBH_MODE_UPDATE_ALL) begin
			wr.converter_load_enable_n = '1;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q    <= DBH_ST_IDLE;
			step_q  <= DBH_STEP_W0;
			mode_q  <= DBH_MODE_WORD;
			tgt_q   <= '0;
			word_q  <= '0;
			load_q  <= 1'b0;
			ready_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			step_q  <= step_d;
			mode_q  <= mode_d;
			tgt_q   <= tgt_d;
			word_q  <= word_d;
			load_q  <= load_d;
			ready_q <= ready_d;
			done_q  <= done_d;
		end
	end

	assign cmd_ready_out = ready_q;
	assign cmd_done_out  = done_q;

	dbh_strobe_gen #(
		.NUM_DACS(NUM_DACS)
	) u_strobe (
		.clk_in                      (clk_in),
		.rst_in                      (rst_in),
		.wr                          (wr.seq),
		.write_strobe_n_out          (write_strobe_n_out),
		.nibble_enable_n_out         (nibble_enable_n_out),
		.converter_load_enable_n_out (converter_load_enable_n_out),
		.data_inputs_out             (data_inputs_out)
	);
endmodule
`default_nettype wire

// [dbh_pkg.sv]
// package: modes, pin field positions and write cycle timing for the converter host
package dbh_pkg;

	// ==========================================================
	// command modes
	typedef enum logic [2:0] {
		DBH_MODE_NIBBLE,
		DBH_MODE_BYTE_RIGHT,
		DBH_MODE_BYTE_LEFT,
		DBH_MODE_WORD,
		DBH_MODE_UPDATE_ALL
	} dbh_mode_type;

	// ==========================================================
	// nibble enable positions (active high inside, inverted at the pins)
	localparam int unsigned DBH_NIB_HI  = 2;
	localparam int unsigned DBH_NIB_MID = 1;
	localparam int unsigned DBH_NIB_LO  = 0;
	localparam int unsigned DBH_NIBS    = 3;
	localparam int unsigned DBH_DATA_W  = 12;
	localparam int unsigned DBH_NUM_DACS = 4;

	localparam logic [2:0] DBH_NIB_NONE    = 3'h0;
	localparam logic [2:0] DBH_NIB_ALL     = 3'h7;
	localparam logic [2:0] DBH_NIB_HI_M    = 3'h4;
	localparam logic [2:0] DBH_NIB_MID_M   = 3'h2;
	localparam logic [2:0] DBH_NIB_LO_M    = 3'h1;
	localparam logic [2:0] DBH_NIB_LOBYTE  = 3'h3;
	localparam logic [2:0] DBH_NIB_HIBYTE  = 3'h6;

	// ==========================================================
	// write cycle timing
	localparam int unsigned DBH_CLK_NS    = 10;
	localparam int unsigned DBH_SETUP_NS  = 10;
	localparam int unsigned DBH_STROBE_NS = 50;
	localparam int unsigned DBH_HOLD_NS   = 10;
	localparam int unsigned DBH_CNT_W     = 8;

	localparam logic [DBH_CNT_W-1:0] DBH_SETUP_CYC =
		DBH_CNT_W'((DBH_SETUP_NS + DBH_CLK_NS - 1) / DBH_CLK_NS);
	localparam logic [DBH_CNT_W-1:0] DBH_STROBE_CYC =
		DBH_CNT_W'((DBH_STROBE_NS + DBH_CLK_NS - 1) / DBH_CLK_NS);
	localparam logic [DBH_CNT_W-1:0] DBH_HOLD_CYC =
		DBH_CNT_W'((DBH_HOLD_NS + DBH_CLK_NS - 1) / DBH_CLK_NS);

	localparam logic [1:0] DBH_STEP_W0 = 2'h0;
	localparam logic [1:0] DBH_STEP_W1 = 2'h1;
	localparam logic [1:0] DBH_STEP_W2 = 2'h2;

endpackage

// [dbh_wr_if.sv]
// interface: one pin write request from the command sequencer to the strobe generator
`timescale 1ns/1ps
`default_nettype none
interface dbh_wr_if #(
	parameter int unsigned NUM_DACS = 4
);
	logic                req;
	logic                busy;
	logic [2:0]          nib;
	logic [NUM_DACS-1:0] tgt;
	logic [NUM_DACS-1:0] converter_load_enable_n;
	logic [11:0]         data;

	modport ctrl (output req, output nib, output tgt, output converter_load_enable_n, output data, input busy);
	modport seq  (input req, input nib, input tgt, input converter_load_enable_n, input data, output busy);
endinterface
`default_nettype wire

// [dbh_strobe_gen.sv]
// module: drives one converter write cycle (setup, strobe low, hold) on the pins
`timescale 1ns/1ps
`default_nettype none
module dbh_strobe_gen #(
	parameter int unsigned NUM_DACS = 4
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	// request from the sequencer
	dbh_wr_if.seq                  wr,
	// converter pins
	output var logic               write_strobe_n_out,
	output var logic [3*NUM_DACS-1:0] nibble_enable_n_out,
	output var logic [NUM_DACS-1:0] converter_load_enable_n_out,
	output var logic [11:0]        data_inputs_out
);
	import dbh_pkg::*;

	typedef enum logic [1:0] {DBH_SG_IDLE, DBH_SG_SETUP, DBH_SG_STROBE, DBH_SG_HOLD} dbh_sg_type;

	dbh_sg_type                st_q, st_d;
	logic [DBH_CNT_W-1:0]      cnt_q, cnt_d;
	logic                      wr_n_q, wr_n_d;
	logic [3*NUM_DACS-1:0]     nib_n_q, nib_n_d;
	logic [NUM_DACS-1:0]       ld_n_q, ld_n_d;
	logic [11:0]               data_q, data_d;

	// ==========================================================
	// next state
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		wr_n_d = wr_n_q;
		nib_n_d = nib_n_q;
		ld_n_d = ld_n_q;
		data_d = data_q;
		unique case (st_q)
			DBH_SG_IDLE: begin
				if (wr.req) begin
					// enables and data settle before the strobe falls
					for (int i = 0; i < NUM_DACS; i++) begin
						nib_n_d[3*i +: 3] = wr.tgt[i] ? ~wr.nib : DBH_NIB_ALL;
					end
					ld_n_d = ~wr.converter_load_enable_n;
					data_d = wr.data;
					cnt_d  = DBH_SETUP_CYC;
					st_d   = DBH_SG_SETUP;
				end
			end
			DBH_SG_SETUP: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == 1) begin
					wr_n_d = 1'b0;
					cnt_d  = DBH_STROBE_CYC;
					st_d   = DBH_SG_STROBE;
				end
			end
			DBH_SG_STROBE: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == 1) begin
					// latches close on this rising edge, so data must still stand
					wr_n_d = 1'b1;
					cnt_d  = DBH_HOLD_CYC;
					st_d   = DBH_SG_HOLD;
				end
			end
			DBH_SG_HOLD: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == 1) begin
					nib_n_d = '1;
					ld_n_d  = '1;
					st_d    = DBH_SG_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q    <= DBH_SG_IDLE;
			cnt_q   <= '0;
			wr_n_q  <= 1'b1;
			nib_n_q <= '1;
			ld_n_q  <= '1;
			data_q  <= '0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			wr_n_q  <= wr_n_d;
			nib_n_q <= nib_n_d;
			ld_n_q  <= ld_n_d;
			data_q  <= data_d;
		end
	end

	assign wr.busy                     = (st_q != DBH_SG_IDLE);
	assign write_strobe_n_out          = wr_n_q;
	assign nibble_enable_n_out         = nib_n_q;
	assign converter_load_enable_n_out = ld_n_q;
	assign data_inputs_out             = data_q;
endmodule
`default_nettype wire

// [dbh_dev_model.sv]
// model of one double-buffered converter input stage, seen from its pins
`timescale 1ns/1ps
`default_nettype none
module dbh_dev_model (
	// converter pins
	input  wire logic        write_strobe_n_in,
	input  wire logic [2:0]  nibble_enable_n_in,
	input  wire logic        converter_load_enable_n_in,
	input  wire logic [11:0] data_inputs_in,
	// latch contents
	output var  logic [11:0] input_word_out,
	output var  logic [11:0] dac_word_out
);
	// ==========================================================
	// level latches: several may be open in one write
	always_latch begin
		if (!write_strobe_n_in && !nibble_enable_n_in[2]) begin
			input_word_out[11:8] <= data_inputs_in[11:8];
		end
	end
	always_latch begin
		if (!write_strobe_n_in && !nibble_enable_n_in[1]) begin
			input_word_out[7:4] <= data_inputs_in[7:4];
		end
	end
	always_latch begin
		if (!write_strobe_n_in && !nibble_enable_n_in[0]) begin
			input_word_out[3:0] <= data_inputs_in[3:0];
		end
	end
	// converter latch apart from the input latches, so preloads stay hidden
	always_latch begin
		if (!write_strobe_n_in && !converter_load_enable_n_in) begin
			dac_word_out <= input_word_out;
		end
	end
endmodule
`default_nettype wire

// [dbh_host_props.sv]
// checker: pin write cycle and command sequencing of the converter host
`timescale 1ns/1ps
`default_nettype none
module dbh_host_props #(
	parameter int unsigned NUM_DACS = 4,
	parameter int unsigned TGT_W    = 2
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  cmd_valid_in,
	input  wire dbh_pkg::dbh_mode_type cmd_mode_in,
	input  wire logic [TGT_W-1:0]      cmd_target_in,
	input  wire logic [11:0]           cmd_word_in,
	input  wire logic                  cmd_load_in,
	input  wire logic                  cmd_ready_out,
	input  wire logic                  cmd_done_out,
	input  wire logic                  write_strobe_n_out,
	input  wire logic [3*NUM_DACS-1:0] nibble_enable_n_out,
	input  wire logic [NUM_DACS-1:0]   converter_load_enable_n_out,
	input  wire logic [11:0]           data_inputs_out
);
	import dbh_pkg::*;
	logic             taken;
	logic [TGT_W-1:0] tgt_d;
	logic [TGT_W-1:0] tgt_q;
	logic [2:0]       nib;
	assign taken = cmd_valid_in && cmd_ready_out;
	assign nib = nibble_enable_n_out[3*tgt_q+:3];
	// ==========================================================
	// target of the command in flight
	always_comb begin
		tgt_d = taken ? cmd_target_in : tgt_q;
	end
	always_ff @(posedge clk_in) begin
		tgt_q <= tgt_d;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// ==========================================================
	// assertions
	a_pins_stable_low: assert property (!write_strobe_n_out && !$past(write_strobe_n_out) |->
		$stable(nibble_enable_n_out) && $stable(converter_load_enable_n_out) &&
		$stable(data_inputs_out)) else $error("pins moved while strobe low");
	a_setup_before_fall: assert property ($fell(write_strobe_n_out) |->
		$stable(nibble_enable_n_out) && $stable(data_inputs_out))
		else $error("pins changed at strobe fall");
	a_strobe_five_low: assert property ($fell(write_strobe_n_out) |->
		(!write_strobe_n_out)[*5] ##1 write_strobe_n_out) else $error("strobe width wrong");
	a_hold_then_idle: assert property ($rose(write_strobe_n_out) |-> $stable(nibble_enable_n_out)
		##1 (&nibble_enable_n_out && &converter_load_enable_n_out)) else $error("hold wrong");
	a_idle_no_enables: assert property (cmd_ready_out |-> write_strobe_n_out &&
		&nibble_enable_n_out && &converter_load_enable_n_out) else $error("enable while idle");
	a_done_with_ready: assert property (cmd_done_out |-> cmd_ready_out && write_strobe_n_out)
		else $error("done without ready");
	a_word_all_nibbles: assert property (taken && cmd_mode_in == DBH_MODE_WORD |->
		##[1:3] nib == 3'h0) else $error("word write lacks all nibbles");
	a_update_all_loads: assert property (taken && cmd_mode_in == DBH_MODE_UPDATE_ALL |->
		##[1:3] (converter_load_enable_n_out == '0 && &nibble_enable_n_out))
		else $error("update all wrong");
	a_right_low_byte: assert property (taken && cmd_mode_in == DBH_MODE_BYTE_RIGHT |->
		##[1:3] (nib == 3'h4 && converter_load_enable_n_out[tgt_q]))
		else $error("right byte order wrong");
	a_left_high_byte: assert property (taken && cmd_mode_in == DBH_MODE_BYTE_LEFT |->
		##[1:3] nib == 3'h1) else $error("left byte order wrong");
	a_nibble_high_first: assert property (taken && cmd_mode_in == DBH_MODE_NIBBLE |->
		##[1:3] nib == 3'h3) else $error("nibble order wrong");
endmodule
bind dbh_host dbh_host_props #(.NUM_DACS(NUM_DACS), .TGT_W(TGT_W)) u_props (
	.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_mode_in(cmd_mode_in),
	.cmd_target_in(cmd_target_in), .cmd_word_in(cmd_word_in), .cmd_load_in(cmd_load_in),
	.cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
	.write_strobe_n_out(write_strobe_n_out), .nibble_enable_n_out(nibble_enable_n_out),
	.converter_load_enable_n_out(converter_load_enable_n_out),
	.data_inputs_out(data_inputs_out));
`default_nettype wire

// [dbh_host_test.sv]
// testbench: host controller driving four converter models
`timescale 1ns/1ps
`default_nettype none
module dbh_host_test;
	import dbh_pkg::*;
	typedef struct {
		dbh_mode_type m;
		logic [1:0]   t;
		logic [11:0]  w;
		logic         l;
		logic [11:0]  ei;
		logic [11:0]  ed;
	} dbh_row_type;
	logic         clk_in;
	logic         rst_in;
	logic         cmd_valid_in;
	dbh_mode_type cmd_mode_in;
	logic [1:0]   cmd_target_in;
	logic [11:0]  cmd_word_in;
	logic         cmd_load_in;
	logic         cmd_ready_out;
	logic         cmd_done_out;
	logic         strobe_n;
	logic [11:0]  nib_n;
	logic [3:0]   load_n;
	logic [11:0]  data;
	logic [11:0]  in_w [4];
	logic [11:0]  dac_w [4];
	int           miscompares = 0;
	int           n_compared = 0;
	int           cycles = 0;
	// preload rows keep the old converter value until the common update
	dbh_row_type  rows [8] = '{
		'{DBH_MODE_WORD,       2'h0, 12'habc, 1'b1, 12'habc, 12'habc},
		'{DBH_MODE_BYTE_RIGHT, 2'h1, 12'h123, 1'b1, 12'h123, 12'h123},
		'{DBH_MODE_BYTE_LEFT,  2'h2, 12'h456, 1'b1, 12'h456, 12'h456},
		'{DBH_MODE_NIBBLE,     2'h3, 12'h789, 1'b1, 12'h789, 12'h789},
		'{DBH_MODE_NIBBLE,     2'h0, 12'h5a5, 1'b0, 12'h5a5, 12'habc},
		'{DBH_MODE_BYTE_RIGHT, 2'h1, 12'hfff, 1'b0, 12'hfff, 12'h123},
		'{DBH_MODE_WORD,       2'h3, 12'h0c3, 1'b0, 12'h0c3, 12'h789},
		'{DBH_MODE_UPDATE_ALL, 2'h0, 12'h000, 1'b1, 12'h5a5, 12'h5a5}};
	dbh_host dut (
		.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
		.cmd_mode_in(cmd_mode_in), .cmd_target_in(cmd_target_in), .cmd_word_in(cmd_word_in),
		.cmd_load_in(cmd_load_in), .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
		.write_strobe_n_out(strobe_n), .nibble_enable_n_out(nib_n),
		.converter_load_enable_n_out(load_n), .data_inputs_out(data));
	for (genvar i = 0; i < 4; i++) begin : g_dev
		dbh_dev_model u_dev (
			.write_strobe_n_in(strobe_n), .nibble_enable_n_in(nib_n[3*i+:3]),
			.converter_load_enable_n_in(load_n[i]), .data_inputs_in(data),
			.input_word_out(in_w[i]), .dac_word_out(dac_w[i]));
	end
	// ==========================================================
	// clock, timeout, reporting
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// valid held until taken; the timeout bounds both waits
	task automatic send(input dbh_mode_type m, input logic [1:0] t, input logic [11:0] w,
		input logic l, input bit wait_done);
		cmd_mode_in <= m;
		cmd_target_in <= t;
		cmd_word_in <= w;
		cmd_load_in <= l;
		cmd_valid_in <= 1'b1;
		do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
		cmd_valid_in <= 1'b0;
		#1 check("ready_busy", {11'h0, cmd_ready_out}, 12'h0);
		if (wait_done) begin
			do @(posedge clk_in); while (cmd_done_out !== 1'b1);
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_in = 1'b1;
		cmd_valid_in = 1'b0;
		cmd_mode_in = DBH_MODE_WORD;
		cmd_target_in = 2'h0;
		cmd_word_in = 12'h000;
		cmd_load_in = 1'b0;
		repeat (16) @(posedge clk_in);
		check("strobe_rst", {11'h0, strobe_n}, 12'h1);
		check("enables_rst", nib_n, 12'hfff);
		rst_in <= 1'b0;
		foreach (rows[i]) begin
			send(rows[i].m, rows[i].t, rows[i].w, rows[i].l, 1'b1);
			check("input_word", in_w[rows[i].t], rows[i].ei);
			check("dac_word", dac_w[rows[i].t], rows[i].ed);
		end
		check("dac1_all", dac_w[1], 12'hfff);
		check("dac3_all", dac_w[3], 12'h0c3);
		// reset in mid write must drop the strobe and every load enable
		send(DBH_MODE_WORD, 2'h2, 12'h0f0, 1'b1, 1'b0);
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1 check("strobe_mid_rst", {11'h0, strobe_n}, 12'h1);
		check("load_mid_rst", {8'h0, load_n}, 12'h00f);
		@(posedge clk_in);
		rst_in <= 1'b0;
		send(DBH_MODE_WORD, 2'h2, 12'h321, 1'b1, 1'b1);
		check("dac2_after_rst", dac_w[2], 12'h321);
		end_of_test();
	end
endmodule
`default_nettype wire
